// file: pkg/pbr_pkg.sv
// pbr_pkg: constants and types for the phy base register bank
package pbr_pkg;

    // register indices as carried in a link request
    localparam logic [3:0] REG_NODE_IDENTITY_STATUS       = 4'h0;
    localparam logic [3:0] REG_ROOT_RESET_GAP_CONTROL     = 4'h1;
    localparam logic [3:0] REG_MAP_AND_PORT_CAPABILITY    = 4'h2;
    localparam logic [3:0] REG_SPEED_AND_DELAY_CAPABILITY = 4'h3;
    localparam logic [3:0] REG_SELF_ID_CONTENT_CONTROL    = 4'h4;
    localparam logic [3:0] REG_EVENT_AND_ENHANCEMENT_CTRL = 4'h5;
    localparam logic [3:0] REG_RESERVED_BYTE              = 4'h6;
    localparam logic [3:0] REG_PAGED_REGISTER_SELECTOR    = 4'h7;

    // bit n of a serial-bus byte is vector index 7-n (bit 0 is the msb)
    localparam int BIT_NODE_ID_LSB      = 2;
    localparam int BIT_ROOT             = 1;
    localparam int BIT_CABLE_POWER      = 0;
    localparam int BIT_ROOT_HOLDOFF     = 7;
    localparam int BIT_LONG_RESET       = 6;
    localparam int BIT_LINK_ON          = 7;
    localparam int BIT_CONTENDER        = 6;
    localparam int BIT_PWR_CLASS_MSB    = 2;
    localparam int BIT_RESUME_INT       = 7;
    localparam int BIT_SHORT_RESET      = 6;
    localparam int BIT_LOOP             = 5;
    localparam int BIT_PWR_FAIL         = 4;
    localparam int BIT_TIMEOUT          = 3;
    localparam int BIT_PORT_EVENT       = 2;
    localparam int BIT_ENAB_ACCEL       = 1;
    localparam int BIT_ENAB_MULTI       = 0;
    localparam int BIT_PAGE_SELECT_LSB  = 5;
    localparam int BIT_PORT_SELECT_MSB  = 3;

    // fixed capability codes and reset values
    localparam logic [2:0] EXTENDED_MAP_CODE = 3'h7;
    localparam logic [3:0] TOTAL_PORTS_CODE  = 4'hC;
    localparam logic [2:0] MAX_SPEED_CODE    = 3'h2;
    localparam logic [3:0] DELAY_CODE        = 4'h0;
    localparam logic [2:0] JITTER_CODE       = 3'h0;
    localparam logic [5:0] GAP_COUNT_RESET   = 6'h3F;
    localparam logic       LINK_ON_RESET     = 1'b1;

    // link request framing
    localparam logic [2:0] REQ_TYPE_READ  = 3'h4;
    localparam logic [2:0] REQ_TYPE_WRITE = 3'h5;
    localparam logic [2:0] TYPE_BITS_LAST = 3'h2;
    localparam logic [2:0] ADDR_BITS_LAST = 3'h3;
    localparam logic [2:0] DATA_BITS_LAST = 3'h7;

    // long bus reset duration, rounded up to whole clock cycles
    localparam int         CLK_PERIOD_NS      = 100;
    localparam int         LONG_RESET_NS      = 167000;
    localparam int         LONG_RESET_CYCLES  =
        (LONG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] LONG_RESET_COUNT  = 11'(LONG_RESET_CYCLES);

    typedef enum logic [2:0] {
        PBR_RX_IDLE = 3'b000,
        PBR_RX_TYPE = 3'b001,
        PBR_RX_ADDR = 3'b010,
        PBR_RX_DATA = 3'b011,
        PBR_RX_STOP = 3'b100,
        PBR_RX_SKIP = 3'b101
    } pbr_rx_state_t;

endpackage

// file: pkg/pbr_link_request_line_if.sv
// pbr_link_request_line_if: decoded register request from the link receiver
`timescale 1ns/1ps
`default_nettype none
interface pbr_link_request_line_if;
    logic       req_valid;
    logic       req_write;
    logic [3:0] req_addr;
    logic [7:0] req_data;

    modport rx   (output req_valid, req_write, req_addr, req_data);
    modport bank (input req_valid, req_write, req_addr, req_data);
endinterface
`default_nettype wire

// file: hdl/pbr_link_request_line_rx.sv
// pbr_link_request_line_rx: deserialises register requests from the link
`timescale 1ns/1ps
`default_nettype none
module pbr_link_request_line_rx
    import pbr_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    reset,
    input  wire logic    link_request_line,
    pbr_link_request_line_if.rx       req
);

    pbr_rx_state_t state;
    pbr_rx_state_t next_state;
    logic [2:0]    bit_cnt;
    logic [2:0]    next_bit_cnt;
    logic [7:0]    shift;
    logic [7:0]    next_shift;
    logic          is_write;
    logic          next_is_write;
    logic          next_valid;
    logic [3:0]    next_addr;
    logic [7:0]    next_data;

    // frame: start 1, type msb first, address, data on writes, stop
    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt + 3'h1;
        next_shift    = {shift[6:0], link_request_line};
        next_is_write = is_write;
        next_valid    = 1'b0;
        next_addr     = req.req_addr;
        next_data     = req.req_data;
        case (state)
            PBR_RX_IDLE: begin
                next_bit_cnt = 3'h0;
                if (link_request_line) begin
                    next_state = PBR_RX_TYPE;
                end
            end
            PBR_RX_TYPE: begin
                if (bit_cnt == TYPE_BITS_LAST) begin
                    next_bit_cnt  = 3'h0;
                    next_is_write = (next_shift[2:0] == REQ_TYPE_WRITE);
                    if (next_shift[2:0] == REQ_TYPE_READ ||
                        next_shift[2:0] == REQ_TYPE_WRITE) begin
                        next_state = PBR_RX_ADDR;
                    end else begin
                        next_state = PBR_RX_SKIP; // other requests are not ours
                    end
                end
            end
            PBR_RX_ADDR: begin
                if (bit_cnt == ADDR_BITS_LAST) begin
                    next_bit_cnt = 3'h0;
                    next_addr    = next_shift[3:0];
                    next_state   = is_write ? PBR_RX_DATA : PBR_RX_STOP;
                end
            end
            PBR_RX_DATA: begin
                if (bit_cnt == DATA_BITS_LAST) begin
                    next_data  = next_shift;
                    next_state = PBR_RX_STOP;
                end
            end
            PBR_RX_STOP: begin
                next_valid = 1'b1; // request goes to the bank
                next_state = PBR_RX_IDLE;
            end
            PBR_RX_SKIP: begin
                if (!link_request_line) begin
                    next_state = PBR_RX_IDLE;
                end
            end
            default: begin
                next_state = PBR_RX_IDLE;
            end
        endcase
    end

    // receiver state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state         <= PBR_RX_IDLE;
            bit_cnt       <= 3'h0;
            shift         <= 8'h00;
            is_write      <= 1'b0;
            req.req_valid <= 1'b0;
            req.req_write <= 1'b0;
            req.req_addr  <= 4'h0;
            req.req_data  <= 8'h00;
        end else begin
            state         <= next_state;
            bit_cnt       <= next_bit_cnt;
            shift         <= next_shift;
            is_write      <= next_is_write;
            req.req_valid <= next_valid;
            req.req_write <= next_is_write;
            req.req_addr  <= next_addr;
            req.req_data  <= next_data;
        end
    end

endmodule
`default_nettype wire

// file: hdl/pbr_phy_base_register_bank.sv
// pbr_phy_base_register_bank: base registers 00h to 07h of a twelve-port phy
// Overview of operation
// - register 00h bits 0..5 read the node id from self-identification
// - register 00h bit 6 reads one once this node is root
// - register 00h bit 7 reads one while cable power is above 7.5V
// - power dropping below 7.5V clears bit 7 and sets power-fail
// - root holdoff bit makes the node try to be root after next reset
// - writing long reset request drives a 167 us long bus reset
// - long reset request bit clears itself once acted upon
// - gap count resets to 3Fh and returns there from the second bus reset
// - gap count is writable and times arbitration gaps
// - register 02h bits 0..2 always read 111
// - register 02h bits 4..7 read port total code 1100
// - register 03h bits 0..2 read speed code 010
// - register 03h bits 4..7 read repeater delay code 0000
// - requests come over the link request line, reads answer to link
// - power-fail flag sets on power falling, cleared by writing one
// - short reset request bit issues an arbitrated reset and self-clears
// - link-active indication is link-on bit AND link power status
`timescale 1ns/1ps
`default_nettype none
module pbr_phy_base_register_bank
    import pbr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       link_request_line,
    input  wire logic       self_id_done,
    input  wire logic [5:0] self_id_node,
    input  wire logic       self_id_root,
    input  wire logic       cable_power_above,
    input  wire logic       link_power_status,
    input  wire logic       bus_reset_seen,
    input  wire logic [2:0] pwr_class_strap,
    input  wire logic       loop_detected,
    input  wire logic       arb_timeout,
    input  wire logic       port_change,
    input  wire logic       resume_start,
    output logic            rd_resp_valid,
    output logic [3:0]      rd_resp_addr,
    output logic [7:0]      rd_resp_data,
    output logic            long_reset_drive,
    output logic            short_reset_issue,
    output logic            root_contend,
    output logic [5:0]      gap_count,
    output logic            link_active_ind,
    output logic            self_id_contender,
    output logic [2:0]      self_id_pwr_class,
    output logic            accel_enable,
    output logic            multi_speed_enable
);

    pbr_link_request_line_if req_bus ();
    // link request receiver
    pbr_link_request_line_rx u_rx (
        .core_clk          (core_clk),
        .reset             (reset),
        .link_request_line (link_request_line),
        .req               (req_bus.rx)
    );

    logic wr_strobe;
    logic rd_strobe;
    logic [7:0] wr_data;

    assign wr_strobe = req_bus.req_valid & req_bus.req_write;
    assign rd_strobe = req_bus.req_valid & ~req_bus.req_write;
    assign wr_data   = req_bus.req_data;

    // node identity and cable power status
    logic [5:0] node_identifier;
    logic [5:0] next_node_identifier;
    logic       node_is_root;
    logic       next_node_is_root;
    logic       cable_power_ok;
    logic       next_cable_power_ok;
    logic       power_fall;

    // capture self-id results and sample the power comparator
    always_comb begin
        next_node_identifier = node_identifier;
        next_node_is_root    = node_is_root;
        if (self_id_done) begin
            next_node_identifier = self_id_node;
            next_node_is_root    = self_id_root;
        end
        next_cable_power_ok = cable_power_above;
    end

    assign power_fall = cable_power_ok & ~cable_power_above;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            node_identifier <= 6'h00;
            node_is_root    <= 1'b0;
            cable_power_ok  <= 1'b0;
        end else begin
            node_identifier <= next_node_identifier;
            node_is_root    <= next_node_is_root;
            cable_power_ok  <= next_cable_power_ok;
        end
    end

    // writable control state
    logic       root_holdoff;
    logic       next_root_holdoff;
    logic       long_reset_request;
    logic       next_long_reset_request;
    logic [5:0] next_gap_count;
    logic       gap_reset_armed;
    logic       next_gap_reset_armed;
    logic       link_on;
    logic       next_link_on;
    logic       contender;
    logic       next_contender;
    logic [2:0] pwr_class;
    logic [2:0] next_pwr_class;
    logic       strap_taken;
    logic       next_strap_taken;
    logic       resume_int;
    logic       next_resume_int;
    logic       short_reset_request;
    logic       next_short_reset_request;
    logic       loop_flag;
    logic       next_loop_flag;
    logic       pwr_fail;
    logic       next_pwr_fail;
    logic       timeout_flag;
    logic       next_timeout_flag;
    logic       port_event;
    logic       next_port_event;
    logic       enab_accel;
    logic       next_enab_accel;
    logic       enab_multi;
    logic       next_enab_multi;
    logic [2:0] page_select;
    logic [2:0] next_page_select;
    logic [3:0] port_select;
    logic [3:0] next_port_select;
    logic       long_start;
    logic       wr01;
    logic       wr04;
    logic       wr05;
    logic       wr07;

    assign wr01 = wr_strobe && req_bus.req_addr == REG_ROOT_RESET_GAP_CONTROL;
    assign wr04 = wr_strobe && req_bus.req_addr == REG_SELF_ID_CONTENT_CONTROL;
    assign wr05 = wr_strobe && req_bus.req_addr == REG_EVENT_AND_ENHANCEMENT_CTRL;
    assign wr07 = wr_strobe && req_bus.req_addr == REG_PAGED_REGISTER_SELECTOR;

    // register writes and event flags
    always_comb begin
        next_root_holdoff        = root_holdoff;
        next_long_reset_request  = long_reset_request & ~long_start;
        next_gap_count           = gap_count;
        next_gap_reset_armed     = gap_reset_armed;
        next_link_on             = link_on;
        next_contender           = contender;
        next_pwr_class           = pwr_class;
        next_strap_taken         = 1'b1;
        next_resume_int          = resume_int;
        next_short_reset_request = 1'b0;
        next_loop_flag           = loop_flag;
        next_pwr_fail            = pwr_fail;
        next_timeout_flag        = timeout_flag;
        next_port_event          = port_event;
        next_enab_accel          = enab_accel;
        next_enab_multi          = enab_multi;
        next_page_select         = page_select;
        next_port_select         = port_select;
        // power class straps are caught on the first edge after reset
        if (!strap_taken) begin
            next_pwr_class = pwr_class_strap;
        end
        // first bus reset after a write keeps the gap, later ones restore it
        if (bus_reset_seen) begin
            next_gap_reset_armed = 1'b1;
            if (gap_reset_armed) begin
                next_gap_count = GAP_COUNT_RESET;
            end
        end
        if (wr01) begin
            next_root_holdoff    = wr_data[BIT_ROOT_HOLDOFF];
            next_gap_count       = wr_data[5:0];
            next_gap_reset_armed = 1'b0;
            if (wr_data[BIT_LONG_RESET]) begin
                next_long_reset_request = 1'b1;
            end
        end
        if (wr04) begin
            next_link_on   = wr_data[BIT_LINK_ON];
            next_contender = wr_data[BIT_CONTENDER];
            next_pwr_class = wr_data[BIT_PWR_CLASS_MSB:0]; // jitter stays fixed
        end
        if (wr05) begin
            next_resume_int          = wr_data[BIT_RESUME_INT];
            next_short_reset_request = wr_data[BIT_SHORT_RESET];
            next_enab_accel          = wr_data[BIT_ENAB_ACCEL];
            next_enab_multi          = wr_data[BIT_ENAB_MULTI];
            if (wr_data[BIT_LOOP]) begin
                next_loop_flag = 1'b0;
            end
            if (wr_data[BIT_PWR_FAIL]) begin
                next_pwr_fail = 1'b0;
            end
            if (wr_data[BIT_TIMEOUT]) begin
                next_timeout_flag = 1'b0;
            end
            if (wr_data[BIT_PORT_EVENT]) begin
                next_port_event = 1'b0;
            end
        end
        if (wr07) begin
            next_page_select = wr_data[7:BIT_PAGE_SELECT_LSB];
            next_port_select = wr_data[BIT_PORT_SELECT_MSB:0];
        end
        // event sets come last so they win a same-cycle clear
        if (power_fall) begin
            next_pwr_fail = 1'b1;
        end
        if (loop_detected) begin
            next_loop_flag = 1'b1;
        end
        if (arb_timeout) begin
            next_timeout_flag = 1'b1;
        end
        if (port_change || (resume_start && resume_int)) begin
            next_port_event = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            root_holdoff        <= 1'b0;
            long_reset_request  <= 1'b0;
            gap_count           <= GAP_COUNT_RESET;
            gap_reset_armed     <= 1'b1;
            link_on             <= LINK_ON_RESET;
            contender           <= 1'b0;
            pwr_class           <= 3'h0;
            strap_taken         <= 1'b0;
            resume_int          <= 1'b0;
            short_reset_request <= 1'b0;
            loop_flag           <= 1'b0;
            pwr_fail            <= 1'b0;
            timeout_flag        <= 1'b0;
            port_event          <= 1'b0;
            enab_accel          <= 1'b0;
            enab_multi          <= 1'b0;
            page_select         <= 3'h0;
            port_select         <= 4'h0;
        end else begin
            root_holdoff        <= next_root_holdoff;
            long_reset_request  <= next_long_reset_request;
            gap_count           <= next_gap_count;
            gap_reset_armed     <= next_gap_reset_armed;
            link_on             <= next_link_on;
            contender           <= next_contender;
            pwr_class           <= next_pwr_class;
            strap_taken         <= next_strap_taken;
            resume_int          <= next_resume_int;
            short_reset_request <= next_short_reset_request;
            loop_flag           <= next_loop_flag;
            pwr_fail            <= next_pwr_fail;
            timeout_flag        <= next_timeout_flag;
            port_event          <= next_port_event;
            enab_accel          <= next_enab_accel;
            enab_multi          <= next_enab_multi;
            page_select         <= next_page_select;
            port_select         <= next_port_select;
        end
    end

    // long bus reset timer and link-active indication
    logic [10:0] long_cnt;
    logic [10:0] next_long_cnt;
    logic        next_long_reset_drive;
    logic        next_link_active_ind;

    // a pending request waits for a running drive to end
    assign long_start = long_reset_request & ~long_reset_drive;

    always_comb begin
        next_long_cnt         = long_cnt;
        next_long_reset_drive = long_reset_drive;
        if (long_start) begin
            next_long_cnt         = LONG_RESET_COUNT - 11'h001;
            next_long_reset_drive = 1'b1;
        end else if (long_reset_drive) begin
            if (long_cnt == 11'h000) begin
                next_long_reset_drive = 1'b0;
            end else begin
                next_long_cnt = long_cnt - 11'h001;
            end
        end
        next_link_active_ind = link_on & link_power_status;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            long_cnt         <= 11'h000;
            long_reset_drive <= 1'b0;
            link_active_ind  <= 1'b0;
        end else begin
            long_cnt         <= next_long_cnt;
            long_reset_drive <= next_long_reset_drive;
            link_active_ind  <= next_link_active_ind;
        end
    end

    // register copies to the arbitration and self-id logic
    assign root_contend       = root_holdoff;
    assign short_reset_issue  = short_reset_request;
    assign self_id_contender  = contender;
    assign self_id_pwr_class  = pwr_class;
    assign accel_enable       = enab_accel;
    assign multi_speed_enable = enab_multi;

    // read multiplexer and answer to the link
    logic [7:0] rd_value;
    logic       next_rd_resp_valid;
    logic [3:0] next_rd_resp_addr;
    logic [7:0] next_rd_resp_data;

    always_comb begin
        case (req_bus.req_addr)
            REG_NODE_IDENTITY_STATUS:
                rd_value = {node_identifier, node_is_root, cable_power_ok};
            REG_ROOT_RESET_GAP_CONTROL:
                rd_value = {root_holdoff, long_reset_request, gap_count};
            REG_MAP_AND_PORT_CAPABILITY:
                rd_value = {EXTENDED_MAP_CODE, 1'b0, TOTAL_PORTS_CODE};
            REG_SPEED_AND_DELAY_CAPABILITY:
                rd_value = {MAX_SPEED_CODE, 1'b0, DELAY_CODE};
            REG_SELF_ID_CONTENT_CONTROL:
                rd_value = {link_on, contender, JITTER_CODE, pwr_class};
            REG_EVENT_AND_ENHANCEMENT_CTRL:
                rd_value = {resume_int, short_reset_request, loop_flag, pwr_fail,
                            timeout_flag, port_event, enab_accel, enab_multi};
            REG_PAGED_REGISTER_SELECTOR:
                rd_value = {page_select, 1'b0, port_select};
            default:
                rd_value = 8'h00; // reserved byte and unmapped reads
        endcase
        next_rd_resp_valid = rd_strobe;
        next_rd_resp_addr  = rd_resp_addr;
        next_rd_resp_data  = rd_resp_data;
        if (rd_strobe) begin
            next_rd_resp_addr = req_bus.req_addr;
            next_rd_resp_data = rd_value;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_resp_valid <= 1'b0;
            rd_resp_addr  <= 4'h0;
            rd_resp_data  <= 8'h00;
        end else begin
            rd_resp_valid <= next_rd_resp_valid;
            rd_resp_addr  <= next_rd_resp_addr;
            rd_resp_data  <= next_rd_resp_data;
        end
    end
endmodule
`default_nettype wire

// file: tb/pbr_bank_props.sv
// pbr_bank_props: port checks for the phy base register bank
`timescale 1ns/1ps
`default_nettype none
module pbr_bank_props (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       rd_resp_valid,
    input wire logic [3:0] rd_resp_addr,
    input wire logic [7:0] rd_resp_data,
    input wire logic       long_reset_drive,
    input wire logic       short_reset_issue,
    input wire logic [5:0] gap_count,
    input wire logic       link_power_status,
    input wire logic       link_active_ind
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [11:0] hi_cnt;
    logic        rv;
    assign rv = rd_resp_valid;
    // cycles the long reset has been driven
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) hi_cnt <= 12'h000;
        else hi_cnt <= long_reset_drive ? hi_cnt + 12'h001 : 12'h000;
    end
    a_long_len: assert property ($fell(long_reset_drive) |-> hi_cnt == 12'h686)
        else $error("long reset length");
    a_short_pulse: assert property (short_reset_issue |=> !short_reset_issue)
        else $error("short reset pulse");
    a_resp_pulse: assert property (rv |=> !rv)
        else $error("answer pulse");
    a_link_low: assert property (!$past(link_power_status) |-> !link_active_ind)
        else $error("link active");
    a_map_ports: assert property (rv && rd_resp_addr == 4'h2 |-> rd_resp_data == 8'hEC)
        else $error("reg 02");
    a_speed_delay: assert property (rv && rd_resp_addr == 4'h3
        |-> rd_resp_data == 8'h40) else $error("reg 03");
    a_rsvd_zero: assert property (rv && (rd_resp_addr == 4'h6 || rd_resp_addr[3])
        |-> rd_resp_data == 8'h00) else $error("reserved read");
    a_gap_read: assert property (rv && rd_resp_addr == 4'h1
        |-> rd_resp_data[5:0] == $past(gap_count)) else $error("gap read");
    c_long: cover property ($fell(long_reset_drive));
    c_short: cover property (short_reset_issue);
    c_gap: cover property (rv && rd_resp_addr == 4'h1);
endmodule
bind pbr_phy_base_register_bank pbr_bank_props pbr_bank_props_i (.core_clk, .reset,
    .rd_resp_valid, .rd_resp_addr, .rd_resp_data, .long_reset_drive, .short_reset_issue,
    .gap_count, .link_power_status, .link_active_ind);
`default_nettype wire

// file: tb/pbr_link_model.sv
// pbr_link_model: link side that serialises register requests
`timescale 1ns/1ps
`default_nettype none
module pbr_link_model (
    input  wire logic core_clk,
    output var logic  link_request_line
);
    initial link_request_line = 1'b0;
    // start, type 10w, address, data on writes, stop; msb first
    task automatic send(input logic wr, input logic [3:0] a, input logic [7:0] d);
        logic [15:0] f;
        f = {2'b11, 1'b0, wr, a, d};
        for (int i = 15; i > (wr ? -1 : 7); i--) begin
            @(posedge core_clk);
            #1 link_request_line = f[i];
        end
        @(posedge core_clk);
        #1 link_request_line = 1'b0;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_phy_base_register_bank.sv
// tb_phy_base_register_bank: self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_phy_base_register_bank;
    logic        core_clk = 1'b0, reset = 1'b1, self_id_done = 1'b0, self_id_root = 1'b1;
    logic        cable_power_above = 1'b1, link_power_status = 1'b1, bus_reset_seen = 1'b0;
    logic        link_request_line, rd_resp_valid, long_reset_drive, short_reset_issue;
    logic        root_contend, link_active_ind;
    logic [5:0]  self_id_node = 6'h00, gap_count, g;
    logic [3:0]  rd_resp_addr;
    logic [7:0]  rd_resp_data, rd;
    logic [15:0] n;
    logic [11:0] cap [4] = '{12'h2EC, 12'h340, 12'h600, 12'hB00};
    int          n_errors = 0, n_tests = 0;
    always #50 core_clk = ~core_clk;
    pbr_phy_base_register_bank pbr_phy_base_register_bank_i (.core_clk, .reset,
        .link_request_line, .self_id_done, .self_id_node, .self_id_root, .cable_power_above,
        .link_power_status, .bus_reset_seen, .pwr_class_strap(3'h0), .loop_detected(1'b0),
        .arb_timeout(1'b0), .port_change(1'b0), .resume_start(1'b0), .rd_resp_valid,
        .rd_resp_addr, .rd_resp_data, .long_reset_drive, .short_reset_issue, .root_contend,
        .gap_count, .link_active_ind, .self_id_contender(), .self_id_pwr_class(),
        .accel_enable(), .multi_speed_enable());
    pbr_link_model pbr_link_model_i (.core_clk, .link_request_line);
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    // read, then wait a bounded time for the answer
    task automatic rdreg(input logic [3:0] a);
        pbr_link_model_i.send(1'b0, a, 8'h00);
        for (int i = 0; i < 8 && rd_resp_valid !== 1'b1; i++) tick();
        chk(8'(rd_resp_addr), 8'(a));
        if (rd_resp_valid !== 1'b1) begin
            n_errors++;
            complete_run();
        end
        rd = rd_resp_data;
    endtask
    task automatic wrreg(input logic [3:0] a, input logic [7:0] d);
        pbr_link_model_i.send(1'b1, a, d);
        repeat (3) tick();
    endtask
    initial begin
        void'($urandom(32'h858C));
        repeat (8) @(posedge core_clk);
        #1 reset = 1'b0;
        self_id_node = 6'($urandom);
        self_id_done = 1'b1;
        tick();
        self_id_done = 1'b0;
        wrreg(4'h0, 8'($urandom));
        rdreg(4'h0);
        chk(rd, {self_id_node, 2'b11});
        cable_power_above = 1'b0;
        rdreg(4'h0);
        chk(rd, {self_id_node, 2'b10});
        rdreg(4'h5);
        chk(rd, 8'h10);
        wrreg(4'h5, 8'h10);
        rdreg(4'h5);
        chk(rd, 8'h00);
        // fixed, reserved and unmapped bytes ignore writes
        foreach (cap[i]) begin
            wrreg(cap[i][11:8], 8'($urandom));
            rdreg(cap[i][11:8]);
            chk(rd, cap[i][7:0]);
        end
        g = 6'($urandom_range(62, 0));
        wrreg(4'h1, {2'b10, g});
        chk({root_contend, 1'b0, gap_count}, {2'b10, g});
        rdreg(4'h1);
        chk(rd, {2'b10, g});
        // first bus reset arms, second restores the gap
        repeat (2) begin
            chk(8'(gap_count), 8'(g));
            bus_reset_seen = 1'b1;
            tick();
            bus_reset_seen = 1'b0;
            tick();
        end
        chk(8'(gap_count), 8'h3F);
        pbr_link_model_i.send(1'b1, 4'h1, 8'h40);
        n = 16'h0000;
        for (int i = 0; i < 2000 && (n == 0 || long_reset_drive === 1'b1); i++) begin
            tick();
            if (long_reset_drive === 1'b1) n++;
        end
        chk(n[15:8], 8'h06);
        chk(n[7:0], 8'h86);
        if (n != 16'h0686) complete_run();
        rdreg(4'h1);
        chk(rd, 8'h00);
        pbr_link_model_i.send(1'b1, 4'h5, 8'h40);
        n = 16'h0000;
        repeat (4) begin
            tick();
            if (short_reset_issue === 1'b1) n++;
        end
        chk(n[7:0], 8'h01);
        rdreg(4'h5);
        chk(rd, 8'h00);
        for (int v = 0; v < 2; v++) begin
            link_power_status = v[0];
            repeat (2) tick();
            chk(8'(link_active_ind), 8'(v[0]));
        end
        complete_run();
    end
endmodule
`default_nettype wire
